//--- cju_alu.sv
`timescale 1ns/1ps
`include "cju_map.svh"
module cju_alu (
  cju_exec_if.alu ex
);
  logic [15:0] sum_w;
  logic [7:0] sum_b;
  logic [15:0] inv_w;
  logic [7:0] inv_b;
  logic [7:0] dlo;
  assign dlo = ex.dst[7:0];
  assign sum_w = ex.dst + `CJU_ADD_STEP;
  assign sum_b = dlo + 8'(`CJU_ADD_STEP);
  assign inv_w = ex.dst ^ `CJU_INV_MASK_W;
  assign inv_b = dlo ^ `CJU_INV_MASK_B;
  always_comb begin
    ex.alu_res = ex.dst;
    ex.alu_wr = 1'b0;
    ex.alu_fupd = 1'b0;
    ex.alu_n = 1'b0;
    ex.alu_z = 1'b0;
    ex.alu_c = 1'b0;
    ex.alu_v = 1'b0;
    case (ex.op)
      cju_pkg::op_add_two: begin
        ex.alu_wr = 1'b1;
        ex.alu_fupd = 1'b1;
        if (ex.byte_mode) begin
          ex.alu_res = {`CJU_HIGH_BYTE_FILL, sum_b};
          ex.alu_n = sum_b[7];
          ex.alu_z = (dlo == `CJU_ADD2_Z_B);
          ex.alu_c = (dlo == `CJU_ADD2_Z_B) || (dlo == `CJU_ADD2_C_B);
          ex.alu_v = (dlo == `CJU_ADD2_V1_B) ||
                     (dlo == `CJU_ADD2_V2_B);
        end else begin
          ex.alu_res = sum_w;
          ex.alu_n = sum_w[15];
          ex.alu_z = (ex.dst == `CJU_ADD2_Z_W);
          ex.alu_c = (ex.dst == `CJU_ADD2_Z_W) ||
                     (ex.dst == `CJU_ADD2_C_W);
          ex.alu_v = (ex.dst == `CJU_ADD2_V1_W) ||
                     (ex.dst == `CJU_ADD2_V2_W);
        end
      end
      cju_pkg::op_ones_complement: begin
        ex.alu_wr = 1'b1;
        ex.alu_fupd = 1'b1;
        if (ex.byte_mode) begin
          ex.alu_res = {`CJU_HIGH_BYTE_FILL, inv_b};
          ex.alu_n = inv_b[7];
          ex.alu_z = (dlo == `CJU_INV_MASK_B);
          ex.alu_c = (dlo != `CJU_INV_MASK_B);
          ex.alu_v = dlo[7];
        end else begin
          ex.alu_res = inv_w;
          ex.alu_n = inv_w[15];
          ex.alu_z = (ex.dst == `CJU_INV_MASK_W);
          ex.alu_c = (ex.dst != `CJU_INV_MASK_W);
          ex.alu_v = ex.dst[15];
        end
      end
      cju_pkg::op_copy_operand: begin
        // A copy into the constant generator is the idle form.
        ex.alu_wr = !ex.cg_dst;
        if (ex.byte_mode) begin
          ex.alu_res = {`CJU_HIGH_BYTE_FILL, ex.src[7:0]};
        end else begin
          ex.alu_res = ex.src;
        end
      end
      default: begin
        ex.alu_res = ex.dst;
      end
    endcase
  end
endmodule

//--- cju_exec_if.sv
`timescale 1ns/1ps
interface cju_exec_if;
  cju_pkg::cju_op_t op;
  logic byte_mode;
  logic cg_dst;
  cju_pkg::cju_word_t dst;
  cju_pkg::cju_word_t src;
  cju_pkg::cju_word_t pc;
  cju_pkg::cju_word_t sr;
  logic [9:0] offset;
  cju_pkg::cju_word_t alu_res;
  logic alu_wr;
  logic alu_fupd;
  logic alu_n;
  logic alu_z;
  logic alu_c;
  logic alu_v;
  cju_pkg::cju_word_t jmp_pc;
  logic jmp_is;
  logic jmp_taken;
  modport ctl(output op, byte_mode, cg_dst, dst, src, pc, sr, offset,
    input alu_res, alu_wr, alu_fupd, alu_n, alu_z, alu_c, alu_v,
    input jmp_pc, jmp_is, jmp_taken);
  modport alu(input op, byte_mode, cg_dst, dst, src,
    output alu_res, alu_wr, alu_fupd, alu_n, alu_z, alu_c, alu_v);
  modport branch_always(input op, offset, pc, sr,
    output jmp_pc, jmp_is, jmp_taken);
endinterface

//--- cju_jump.sv
`timescale 1ns/1ps
`include "cju_map.svh"
module cju_jump (
  cju_exec_if.branch_always ex
);
  logic c;
  logic z;
  logic n;
  logic v;
  logic [15:0] disp;
  assign c = ex.sr[`CJU_SR_C];
  assign z = ex.sr[`CJU_SR_Z];
  assign n = ex.sr[`CJU_SR_N];
  assign v = ex.sr[`CJU_SR_V];
  assign disp = {{5{ex.offset[9]}}, ex.offset, 1'b0};
  always_comb begin
    ex.jmp_is = 1'b1;
    ex.jmp_taken = 1'b0;
    case (ex.op)
      cju_pkg::op_branch_carry_set: ex.jmp_taken = c;
      cju_pkg::op_branch_carry_clear: ex.jmp_taken = !c;
      cju_pkg::op_branch_equal: ex.jmp_taken = z;
      cju_pkg::op_branch_not_equal: ex.jmp_taken = !z;
      cju_pkg::op_branch_on_negative: ex.jmp_taken = n;
      cju_pkg::op_branch_signed_ge: ex.jmp_taken = !(n ^ v);
      cju_pkg::op_branch_signed_less: ex.jmp_taken = n ^ v;
      cju_pkg::op_branch_always: ex.jmp_taken = 1'b1;
      default: ex.jmp_is = 1'b0;
    endcase
  end
  // The offset counts from the following word, since one step is added to the
  // counter along with the offset; this gives the -511 to +512 reach.
  assign ex.jmp_pc = ex.jmp_taken ? 16'(ex.pc + `CJU_PC_STEP + disp) :
                     16'(ex.pc + `CJU_PC_STEP);
endmodule

//--- cju_map.svh
`ifndef CJU_MAP_SVH
`define CJU_MAP_SVH
`define CJU_OFF_INSTR 8'h00
`define CJU_OFF_DST 8'h04
`define CJU_OFF_SRC 8'h08
`define CJU_OFF_SR 8'h0c
`define CJU_OFF_PC 8'h10
`define CJU_OFF_STAT 8'h14
`define CJU_INSTR_OFFS_LSB 0
`define CJU_INSTR_OFFS_MSB 9
`define CJU_INSTR_OP_LSB 10
`define CJU_INSTR_OP_MSB 13
`define CJU_INSTR_BYTE_BIT 14
`define CJU_INSTR_CG_BIT 15
`define CJU_SR_C 0
`define CJU_SR_Z 1
`define CJU_SR_N 2
`define CJU_SR_GIE 3
`define CJU_SR_CORE_HALT 4
`define CJU_SR_OSCILLATOR_DISABLE 5
`define CJU_SR_V 8
`define CJU_ADD_STEP 16'h0002
`define CJU_PC_STEP 16'h0002
`define CJU_ADD2_Z_W 16'hfffe
`define CJU_ADD2_C_W 16'hffff
`define CJU_ADD2_V1_W 16'h7ffe
`define CJU_ADD2_V2_W 16'h7fff
`define CJU_ADD2_Z_B 8'hfe
`define CJU_ADD2_C_B 8'hff
`define CJU_ADD2_V1_B 8'h7e
`define CJU_ADD2_V2_B 8'h7f
`define CJU_INV_MASK_W 16'hffff
`define CJU_INV_MASK_B 8'hff
`define CJU_HIGH_BYTE_FILL 8'h00
`define CJU_RST_WORD 16'h0000
`define CJU_RST_COUNT 16'h0000
`define CJU_RESP_OKAY 2'h0
`define CJU_RESP_SLVERR 2'h2
`endif

//--- cju_pkg.sv
package cju_pkg;
  typedef enum logic [3:0] {
    op_idle,
    op_add_two,
    op_ones_complement,
    op_copy_operand,
    op_branch_carry_set,
    op_branch_carry_clear,
    op_branch_equal,
    op_branch_not_equal,
    op_branch_on_negative,
    op_branch_signed_ge,
    op_branch_signed_less,
    op_branch_always
  } cju_op_t;
  typedef logic [15:0] cju_word_t;
endpackage

//--- cju_prog_mem.sv
`timescale 1ns/1ps
// -----------------------------------------------------------------
// Program memory holding instruction words and operands.
// -----------------------------------------------------------------
module cju_prog_mem (
  input wire logic [3:0] idx,
  output logic [15:0] ins,
  output logic [15:0] dst,
  output logic [15:0] src
);
  always_comb begin
    ins = 16'h0000;
    dst = 16'h1234;
    src = 16'h0000;
    case (idx)
      4'h0: begin ins = 16'h0400; dst = 16'hfffe; end
      4'h1: begin ins = 16'h0400; dst = 16'h7fff; end
      4'h2: begin ins = 16'h4400; dst = 16'h127e; end
      4'h3: begin ins = 16'h4400; dst = 16'h12ff; end
      4'h4: begin ins = 16'h0800; dst = 16'hffff; end
      4'h5: begin ins = 16'h0800; dst = 16'h00ae; end
      4'h6: begin ins = 16'h4800; dst = 16'h5580; end
      4'h7: begin ins = 16'h0c00; dst = 16'h0000; src = 16'hbeef; end
      4'h8: begin ins = 16'h4c00; dst = 16'h0000; src = 16'h12a5; end
      4'h9: ins = 16'h8c00;
      4'hb: ins = 16'h2dff;
      4'hc: ins = 16'h2e00;
      default: ins = 16'h0000;
    endcase
  end
endmodule

//--- cju_top.sv
// Contract
// - add_two adds two to destination, word/byte.
// - add_two zero flag on 0FFFEh or 0FEh.
// - add_two carry on FFFE/FFFF or FE/FF.
// - add_two overflow on 7FFE/7FFF or 7E/7F.
// - Negative flag follows result's top bit.
// - ones_complement inverts destination bitwise.
// - ones_complement zero flag when destination all ones.
// - ones_complement carry is inverse of zero.
// - ones_complement overflow when destination was negative.
// - Mode bits untouched by these operations.
// - Taken jump adds doubled offset; else step.
// - branch_carry_set jumps when carry set.
// - branch_carry_clear jumps when carry clear.
// - branch_equal jumps when zero set.
// - branch_not_equal jumps when zero clear.
// - branch_on_negative jumps when negative set.
// - branch_signed_ge jumps when negative equals overflow.
// - branch_signed_less jumps when negative differs overflow.
// - branch_always jumps unconditionally.
// - Jumps and copy leave flags unchanged.
// - copy_operand moves source into destination.
// - idle_instruction changes no state; here it still advances the execution count and clears the taken bit.
//
// Chosen here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "cju_map.svh"
module cju_top #(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic [15:0] core_pc,
  output logic [15:0] core_sr
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic awready_ff;
  logic wready_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic arready_ff;
  logic rvalid_ff;
  logic [1:0] rresp_ff;
  logic [31:0] rdata_ff;
  logic [15:0] instr_ff;
  logic [15:0] dst_ff;
  logic [15:0] src_ff;
  logic [15:0] sr_ff;
  logic [15:0] pc_ff;
  logic exec_ff;
  logic taken_ff;
  logic [15:0] count_ff;

  logic wr_fire;
  logic rd_fire;
  logic [7:0] wa;
  logic [7:0] ra;
  logic wa_hit;
  logic ra_hit;
  logic [31:0] wmask;
  logic [31:0] nxt_rdata;
  logic [15:0] nxt_sr;

  cju_exec_if ex ();

  // ----------------------------------------------------------------
  // Byte lanes
  // ----------------------------------------------------------------
  // Each strobe bit enables its own byte, so narrow stores are exact.
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lane
      assign wmask[8*gi +: 8] = {8{wstrb[gi]}};
    end
  endgenerate

  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [31:0] data,
                                        input logic [31:0] mask);
    merge = (old & ~mask[15:0]) | (data[15:0] & mask[15:0]);
  endfunction

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  assign wa = 8'(awaddr);
  assign ra = 8'(araddr);
  assign wr_fire = awvalid && awready_ff && wvalid && wready_ff;
  assign rd_fire = arvalid && arready_ff;

  always_comb begin
    wa_hit = 1'b0;
    case (wa)
      `CJU_OFF_INSTR: wa_hit = 1'b1;
      `CJU_OFF_DST: wa_hit = 1'b1;
      `CJU_OFF_SRC: wa_hit = 1'b1;
      `CJU_OFF_SR: wa_hit = 1'b1;
      `CJU_OFF_PC: wa_hit = 1'b1;
      `CJU_OFF_STAT: wa_hit = 1'b1;
      default: wa_hit = 1'b0;
    endcase
  end

  always_comb begin
    ra_hit = 1'b1;
    nxt_rdata = 32'h00000000;
    case (ra)
      `CJU_OFF_INSTR: nxt_rdata = {16'h0000, instr_ff};
      `CJU_OFF_DST: nxt_rdata = {16'h0000, dst_ff};
      `CJU_OFF_SRC: nxt_rdata = {16'h0000, src_ff};
      `CJU_OFF_SR: nxt_rdata = {16'h0000, sr_ff};
      `CJU_OFF_PC: nxt_rdata = {16'h0000, pc_ff};
      `CJU_OFF_STAT: nxt_rdata = {count_ff, 14'h0000, exec_ff, taken_ff};
      default: ra_hit = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------
  // Address and data are taken on the same edge; one ready pulse each
  // avoids a half-taken write that would need its own holding state.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
    end else if (awvalid && wvalid && !awready_ff && !bvalid_ff) begin
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
    end else begin
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= `CJU_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= wa_hit ? `CJU_RESP_OKAY : `CJU_RESP_SLVERR;
    end else if (bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b0;
    end else if (arvalid && !arready_ff && !rvalid_ff) begin
      arready_ff <= 1'b1;
    end else begin
      arready_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rresp_ff <= `CJU_RESP_OKAY;
      rdata_ff <= 32'h00000000;
    end else if (rd_fire) begin
      rvalid_ff <= 1'b1;
      rresp_ff <= ra_hit ? `CJU_RESP_OKAY : `CJU_RESP_SLVERR;
      rdata_ff <= nxt_rdata;
    end else if (rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Instruction issue
  // ----------------------------------------------------------------
  // Writing the instruction word starts one execution on the next edge.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      instr_ff <= `CJU_RST_WORD;
    end else if (wr_fire && wa == `CJU_OFF_INSTR) begin
      instr_ff <= merge(instr_ff, wdata, wmask);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      exec_ff <= 1'b0;
    end else begin
      exec_ff <= wr_fire && (wa == `CJU_OFF_INSTR) && (wstrb[1:0] != 2'h0);
    end
  end

  // ----------------------------------------------------------------
  // Execution datapath
  // ----------------------------------------------------------------
  assign ex.op = cju_pkg::cju_op_t'(
    instr_ff[`CJU_INSTR_OP_MSB:`CJU_INSTR_OP_LSB]);
  assign ex.byte_mode = instr_ff[`CJU_INSTR_BYTE_BIT];
  assign ex.cg_dst = instr_ff[`CJU_INSTR_CG_BIT];
  assign ex.offset = instr_ff[`CJU_INSTR_OFFS_MSB:`CJU_INSTR_OFFS_LSB];
  assign ex.dst = dst_ff;
  assign ex.src = src_ff;
  assign ex.pc = pc_ff;
  assign ex.sr = sr_ff;

  cju_alu u_alu (
    .ex(ex.alu)
  );

  cju_jump u_jump (
    .ex(ex.branch_always)
  );

  // Only the four condition flags are rewritten; mode bits pass through.
  always_comb begin
    nxt_sr = sr_ff;
    if (ex.alu_fupd) begin
      nxt_sr[`CJU_SR_N] = ex.alu_n;
      nxt_sr[`CJU_SR_Z] = ex.alu_z;
      nxt_sr[`CJU_SR_C] = ex.alu_c;
      nxt_sr[`CJU_SR_V] = ex.alu_v;
    end
  end

  // ----------------------------------------------------------------
  // Architectural state
  // ----------------------------------------------------------------
  // Execution never shares an edge with a register write, because a
  // new write waits for the previous response to be taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dst_ff <= `CJU_RST_WORD;
    end else if (exec_ff && ex.alu_wr) begin
      dst_ff <= ex.alu_res;
    end else if (wr_fire && wa == `CJU_OFF_DST) begin
      dst_ff <= merge(dst_ff, wdata, wmask);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_ff <= `CJU_RST_WORD;
    end else if (wr_fire && wa == `CJU_OFF_SRC) begin
      src_ff <= merge(src_ff, wdata, wmask);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sr_ff <= `CJU_RST_WORD;
    end else if (exec_ff) begin
      sr_ff <= nxt_sr;
    end else if (wr_fire && wa == `CJU_OFF_SR) begin
      sr_ff <= merge(sr_ff, wdata, wmask);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc_ff <= `CJU_RST_WORD;
    end else if (exec_ff && ex.jmp_is) begin
      pc_ff <= ex.jmp_pc;
    end else if (wr_fire && wa == `CJU_OFF_PC) begin
      pc_ff <= merge(pc_ff, wdata, wmask);
    end
  end

  // ----------------------------------------------------------------
  // Status
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      taken_ff <= 1'b0;
    end else if (exec_ff) begin
      taken_ff <= ex.jmp_is && ex.jmp_taken;
    end
  end

  // Wraps silently; software compares snapshots.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_ff <= `CJU_RST_COUNT;
    end else if (exec_ff) begin
      count_ff <= count_ff + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign awready = awready_ff;
  assign wready = wready_ff;
  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;
  assign arready = arready_ff;
  assign rvalid = rvalid_ff;
  assign rresp = rresp_ff;
  assign rdata = rdata_ff;
  assign core_pc = pc_ff;
  assign core_sr = sr_ff;

endmodule

//--- cju_top_chk.sv
`timescale 1ns/1ps
module cju_top_chk #(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [15:0] core_pc,
  input wire logic [15:0] core_sr
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic wtake;
  logic ex_w;
  logic rtake;
  logic [3:0] wop;
  logic [15:0] jofs;
  assign wtake = awvalid && awready && wvalid && wready;
  assign ex_w = wtake && awaddr == '0 && wstrb[1:0] != 2'h0;
  assign rtake = arvalid && arready;
  assign wop = wdata[13:10];
  // Doubled and sign-extended offset, so the sum wraps like the counter.
  assign jofs = {{5{wdata[9]}}, wdata[9:0], 1'b0};
  a_write_resp: assert property (wtake |=> bvalid)
    else $error("write response missing");
  a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  a_read_resp: assert property (rtake |=> rvalid)
    else $error("read response missing");
  a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  a_aw_blocked: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while response pending");
  a_write_unmapped: assert property (wtake && awaddr > 8'h14 |=> bresp == 2'h2)
    else $error("unmapped write not refused");
  a_read_unmapped: assert property (rtake && araddr > 8'h14 |=>
    rresp == 2'h2 && rdata == 32'h0)
    else $error("unmapped read not refused");
  a_jump_flags: assert property (
    ex_w && wop inside {[4'h4:4'hb]} |-> ##2 core_sr == $past(core_sr, 2))
    else $error("jump changed status");
  a_mode_bits: assert property (
    ex_w && wop inside {[4'h1:4'h3]} |-> ##2
    core_sr[5:3] == $past(core_sr[5:3], 2))
    else $error("mode bits changed");
  a_pc_still: assert property (
    ex_w && wop < 4'h4 |-> ##2 core_pc == $past(core_pc, 2))
    else $error("non-jump moved counter");
  a_jump_always: assert property (
    ex_w && wop == 4'hb |-> ##2
    core_pc == $past(core_pc, 2) + 16'h0002 + $past(jofs, 2))
    else $error("unconditional jump target wrong");
endmodule
bind cju_top cju_top_chk #(.ADDR_W(ADDR_W)) i_cju_top_chk (.*);

//--- test_cpu_jump_and_unary_ops.sv
`timescale 1ns/1ps
module test_cpu_jump_and_unary_ops;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = '0;
  logic awvalid = 1'b0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic [7:0] araddr = '0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] core_pc, core_sr, r_ins, r_dst, r_src, ins;
  logic [3:0] rom_idx = '0;
  logic [1:0] r;
  logic [31:0] d;
  logic [15:0] tk [7] = '{16'h1, 16'h0, 16'h2, 16'h0, 16'h4, 16'h104, 16'h100};
  logic [15:0] nt [7] = '{16'h0, 16'h1, 16'h0, 16'h2, 16'h0, 16'h4, 16'h104};
  int n_fail = 0;
  int checks_done = 0;
  always #20 aclk = ~aclk;
  cju_top #(.ADDR_W(8)) i_cju_top (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .core_pc(core_pc),
    .core_sr(core_sr));
  cju_prog_mem i_cju_prog_mem (.idx(rom_idx), .ins(r_ins), .dst(r_dst),
    .src(r_src));
  // -----------------------------------------------------------------
  // Verdict and comparisons.
  // -----------------------------------------------------------------
  task finish_test;
    if (n_fail == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task cmp32(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask
  task cmp2(input string nm, input logic [1:0] e, input logic [1:0] g);
    checks_done++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask
  // -----------------------------------------------------------------
  // Bus cycles; each ends one edge after the answer, so no signal is
  // assigned twice in one time step by back-to-back calls.
  // -----------------------------------------------------------------
  task axi_wr(input logic [7:0] a, input logic [15:0] v, input logic [3:0] s);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= {16'h0, v};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin @(posedge aclk); n++; end
    while ((awready & wready) !== 1'b1 && n < 50);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    // A late ready lets the response hold checks see a stalled answer.
    @(posedge aclk);
    n++;
    bready <= 1'b1;
    do begin @(posedge aclk); n++; end while (bvalid !== 1'b1 && n < 100);
    r = bresp;
    bready <= 1'b0;
    if (n >= 100) begin n_fail++; finish_test(); end
    @(posedge aclk);
  endtask
  task axi_rd(input logic [7:0] a);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do begin @(posedge aclk); n++; end while (arready !== 1'b1 && n < 50);
    arvalid <= 1'b0;
    @(posedge aclk);
    n++;
    rready <= 1'b1;
    do begin @(posedge aclk); n++; end while (rvalid !== 1'b1 && n < 100);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n >= 100) begin n_fail++; finish_test(); end
    @(posedge aclk);
  endtask
  // Loads operands, executes one word, then reads back dst, src, sr and pc but not the status word.
  task run_case(input logic [15:0] i, dv, sv, sr, ed, es, ep);
    axi_wr(8'h04, dv, 4'hf);
    axi_wr(8'h08, sv, 4'hf);
    axi_wr(8'h0c, sr, 4'hf);
    axi_wr(8'h10, 16'h0100, 4'hf);
    axi_wr(8'h00, i, 4'h3);
    axi_rd(8'h04);
    cmp32("dst", {16'h0, ed}, d);
    axi_rd(8'h08);
    cmp32("src", {16'h0, sv}, d);
    axi_rd(8'h0c);
    cmp32("sr", {16'h0, es}, d);
    axi_rd(8'h10);
    cmp32("pc", {16'h0, ep}, d);
    cmp32("core_pc", {16'h0, ep}, {16'h0, core_pc});
    cmp32("core_sr", {16'h0, es}, {16'h0, core_sr});
  endtask
  task run_rom(input logic [3:0] k, input logic [15:0] ed, es, ep);
    rom_idx <= k;
    @(posedge aclk);
    run_case(r_ins, r_dst, r_src, 16'h013f, ed, es, ep);
  endtask
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    run_rom(4'h0, 16'h0000, 16'h003b, 16'h0100);
    run_rom(4'h1, 16'h8001, 16'h013c, 16'h0100);
    run_rom(4'h2, 16'h0080, 16'h013c, 16'h0100);
    run_rom(4'h3, 16'h0001, 16'h0039, 16'h0100);
    run_rom(4'h4, 16'h0000, 16'h013a, 16'h0100);
    run_rom(4'h5, 16'hff51, 16'h003d, 16'h0100);
    run_rom(4'h6, 16'h007f, 16'h0139, 16'h0100);
    run_rom(4'h7, 16'hbeef, 16'h013f, 16'h0100);
    run_rom(4'h8, 16'h00a5, 16'h013f, 16'h0100);
    run_rom(4'h9, 16'h1234, 16'h013f, 16'h0100);
    run_rom(4'ha, 16'h1234, 16'h013f, 16'h0100);
    run_rom(4'hb, 16'h1234, 16'h013f, 16'h0500);
    run_rom(4'hc, 16'h1234, 16'h013f, 16'hfd02);
    for (int k = 0; k < 7; k++) begin
      ins = {2'b00, 4'(k + 4), 10'h3fb};
      run_case(ins, 16'h1111, 16'h0, tk[k], 16'h1111, tk[k],
        16'h00f8);
      run_case(ins, 16'h1111, 16'h0, nt[k], 16'h1111, nt[k],
        16'h0102);
    end
    run_case(16'h3000, 16'h1111, 16'h0, 16'h013f, 16'h1111, 16'h013f,
      16'h0100);
    axi_rd(8'h14);
    cmp32("stat", 32'h001c0000, d);
    axi_wr(8'h18, 16'h0, 4'hf);
    cmp2("bresp", 2'h2, r);
    axi_rd(8'h18);
    cmp2("rresp", 2'h2, r);
    cmp32("rdata", 32'h0, d);
    finish_test();
  end
endmodule
